//--- common/bms_pkg.sv
// Boot mode selector package: modes, outcomes, carriers and timing.
// Assumes a single 125 MHz system clock domain.
package bms_pkg;
  typedef enum logic [1:0]
  {
    BMS_MODE_USER,
    BMS_MODE_LOADER,
    BMS_MODE_SELECTIVE,
    BMS_MODE_HALT
  } bms_mode_e;

  typedef enum logic [1:0]
  {
    BMS_CHAN_NONE,
    BMS_CHAN_UART,
    BMS_CHAN_CAN
  } bms_chan_e;

  // Config pin bit positions
  localparam int BMS_CFG_LO = 0;
  localparam int BMS_CFG_HI = 1;
  localparam logic [1:0] BMS_CFG_RESET = 2'h3;

  // Key outcome codes (values are arbitrary defaults)
  localparam logic [15:0] BMS_KEY_LOADER = 16'h0001;
  localparam logic [15:0] BMS_KEY_UART = 16'h0002;
  localparam logic [15:0] BMS_KEY_CAN = 16'h0003;

  // Software reset pulse length
  localparam int BMS_SRST_NS = 64;
  localparam int BMS_CLK_NS = 8;
  localparam int BMS_SRST_CYC = (BMS_SRST_NS + BMS_CLK_NS - 1) / BMS_CLK_NS;

  typedef struct packed
  {
    logic user_map;
    logic fetch_redirect;
    logic uart_en;
    logic can_en;
  } bms_map_s;

  typedef struct packed
  {
    logic valid;
    bms_chan_e chan;
  } bms_boot_s;
endpackage

//--- core/bms_boot_mode_selector.sv
// Boot mode selector: latches config pins at reset release, picks mode.
// Assumes pins synchronous to clk; reset_input_pin is the external reset.
// Functional notes
// RQ1: Latch config pins on reset rising edge
// RQ2: Both high: user mode, flash at zero
// RQ3: High-low: standard loader, fetch redirected to ROM
// RQ4: Low-high: selective boot, fetch redirected
// RQ5: Both low reserved: flag, default mode
// RQ6: Loader watches UART and CAN together
// RQ7: UART start condition selects UART boot
// RQ8: CAN dominant bit selects CAN boot
// RQ9: Sum two flash words, compare reference
// RQ10: Match: software reset, run user code
// RQ11: Mismatch: key selects one of four
// RQ12: Unknown key defaults to halt
`timescale 1ns/10ps
`default_nettype none
module bms_boot_mode_selector #(
  parameter int W = 16,
  parameter bms_pkg::bms_mode_e RESERVED_MODE = bms_pkg::BMS_MODE_USER
) (
  input wire logic clk,
  input wire logic arst_n,
  input wire logic reset_input_pin_n,
  input wire logic [1:0] boot_config_pins,
  input wire logic init_done,
  input wire logic uart_receive_line,
  input wire logic can_receive_line,
  input wire logic [W-1:0] sig_word_a,
  input wire logic [W-1:0] sig_word_b,
  input wire logic [W-1:0] ref_sig,
  input wire logic [W-1:0] key_word,
  output bms_pkg::bms_mode_e mode,
  output bms_pkg::bms_map_s map,
  output bms_pkg::bms_boot_s boot,
  output logic reserved_cfg,
  output logic soft_reset,
  output logic halted
);
  import bms_pkg::*;

  typedef enum logic [2:0]
  {
    S_RESET,
    S_DECODE,
    S_CHECK,
    S_WAIT_SIG,
    S_SRST,
    S_SCAN,
    S_DONE,
    S_HALT
  } bms_state_e;

  logic [1:0] rst_sync_q;
  logic rst_n;
  logic pin_q;
  logic [1:0] cfg_q;
  bms_state_e state_q;
  logic sig_start;
  logic sig_done;
  logic sig_match;
  logic [3:0] srst_cnt_q;
  logic uart_ok_q;
  logic can_ok_q;

  // Reset release through two flops
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      rst_sync_q <= 2'h0;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end
  assign rst_n = rst_sync_q[1];

  // Catch pins while external reset is low, freeze on its rising edge
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_q <= 1'b1; // Idle level, so no false rise after reset
      cfg_q <= BMS_CFG_RESET;
    end
    else
    begin
      pin_q <= reset_input_pin_n;
      if (!reset_input_pin_n)
        cfg_q <= boot_config_pins; // RQ1
    end
  end

  assign sig_start = (state_q == S_CHECK);

  bms_sig_check #(.W(W)) u_sig (
    .clk(clk),
    .rst_n(rst_n),
    .start(sig_start),
    .word_a(sig_word_a),
    .word_b(sig_word_b),
    .ref_sig(ref_sig),
    .done(sig_done),
    .match(sig_match)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_q <= S_RESET;
      mode <= BMS_MODE_USER;
      map <= '0;
      boot <= '0;
      reserved_cfg <= 1'b0;
      soft_reset <= 1'b0;
      halted <= 1'b0;
      srst_cnt_q <= 4'h0;
      uart_ok_q <= 1'b0;
      can_ok_q <= 1'b0;
    end
    else
    begin
      soft_reset <= 1'b0;
      unique case (state_q)
        S_RESET:
          if (reset_input_pin_n && !pin_q)
            state_q <= S_DECODE;
        S_DECODE:
        begin
          boot <= '0;
          unique case (cfg_q)
            2'h3:
            begin
              mode <= BMS_MODE_USER;
              map <= '{user_map: 1'b1, fetch_redirect: 1'b0, uart_en: 1'b0, can_en: 1'b0}; // RQ2
              state_q <= S_DONE;
            end
            2'h2:
            begin
              mode <= BMS_MODE_LOADER;
              map <= '{user_map: 1'b1, fetch_redirect: 1'b1, uart_en: 1'b1, can_en: 1'b1}; // RQ3
              state_q <= S_SCAN;
            end
            2'h1:
            begin
              mode <= BMS_MODE_SELECTIVE;
              map <= '{user_map: 1'b1, fetch_redirect: 1'b1, uart_en: 1'b0, can_en: 1'b0}; // RQ4
              state_q <= S_CHECK;
            end
            2'h0:
            begin
              reserved_cfg <= 1'b1; // RQ5
              mode <= RESERVED_MODE;
              map <= '{user_map: 1'b1, fetch_redirect: 1'b0, uart_en: 1'b0, can_en: 1'b0};
              state_q <= S_DONE;
            end
          endcase
        end
        S_CHECK:
          state_q <= S_WAIT_SIG;
        S_WAIT_SIG:
        begin
          if (sig_done)
          begin
            if (sig_match)
            begin
              srst_cnt_q <= 4'(BMS_SRST_CYC);
              state_q <= S_SRST; // RQ10
            end
            else if (key_word == BMS_KEY_LOADER) // RQ11
            begin
              mode <= BMS_MODE_LOADER;
              map.uart_en <= 1'b1;
              map.can_en <= 1'b1;
              state_q <= S_SCAN;
            end
            else if (key_word == BMS_KEY_UART)
            begin
              map.uart_en <= 1'b1;
              state_q <= S_SCAN;
            end
            else if (key_word == BMS_KEY_CAN)
            begin
              map.can_en <= 1'b1;
              state_q <= S_SCAN;
            end
            else
            begin
              mode <= BMS_MODE_HALT; // RQ12
              halted <= 1'b1;
              state_q <= S_HALT;
            end
          end
        end
        S_SRST:
        begin
          soft_reset <= 1'b1; // RQ10
          srst_cnt_q <= srst_cnt_q - 4'h1;
          if (srst_cnt_q == 4'h1)
          begin
            mode <= BMS_MODE_USER;
            map <= '{user_map: 1'b1, fetch_redirect: 1'b0, uart_en: 1'b0, can_en: 1'b0};
            state_q <= S_DONE;
          end
        end
        S_SCAN:
        begin
          // Lines idle high; wait for init and one idle sample first
          if (init_done)
          begin
            uart_ok_q <= uart_receive_line | uart_ok_q;
            can_ok_q <= can_receive_line | can_ok_q;
            // UART wins a same-cycle tie
            if (map.uart_en && uart_ok_q && !uart_receive_line) // RQ6 RQ7
            begin
              boot <= '{valid: 1'b1, chan: BMS_CHAN_UART};
              state_q <= S_DONE;
            end
            else if (map.can_en && can_ok_q && !can_receive_line) // RQ6 RQ8
            begin
              boot <= '{valid: 1'b1, chan: BMS_CHAN_CAN};
              state_q <= S_DONE;
            end
          end
        end
        S_DONE, S_HALT:
          state_q <= state_q;
      endcase
      // External reset wins in every state, even mid-check or mid-scan
      if (!reset_input_pin_n)
      begin
        reserved_cfg <= 1'b0;
        halted <= 1'b0;
        uart_ok_q <= 1'b0;
        can_ok_q <= 1'b0;
        state_q <= S_RESET;
      end
    end
  end

  property p_user_map;
    @(posedge clk) disable iff (!rst_n)
    (state_q == S_DECODE && cfg_q == 2'h3) |=> (mode == BMS_MODE_USER && !map.fetch_redirect);
  endproperty
  a_user_map: assert property (p_user_map) else $error("user mode decode wrong"); // RQ2

  property p_loader;
    @(posedge clk) disable iff (!rst_n)
    (state_q == S_DECODE && cfg_q == 2'h2) |=> (mode == BMS_MODE_LOADER && map.fetch_redirect);
  endproperty
  a_loader: assert property (p_loader) else $error("loader decode wrong"); // RQ3

  property p_selective;
    @(posedge clk) disable iff (!rst_n)
    (state_q == S_DECODE && cfg_q == 2'h1) |=> ##1 sig_done;
  endproperty
  a_selective: assert property (p_selective) else $error("selective check not run"); // RQ4

  property p_reserved;
    @(posedge clk) disable iff (!rst_n)
    (state_q == S_DECODE && cfg_q == 2'h0) |=> (reserved_cfg && mode == RESERVED_MODE);
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved not flagged"); // RQ5

  sequence s_uart_start;
    state_q == S_SCAN && init_done && map.uart_en && uart_ok_q && !uart_receive_line;
  endsequence
  property p_uart;
    @(posedge clk) disable iff (!rst_n)
    s_uart_start |=> (boot.valid && boot.chan == BMS_CHAN_UART);
  endproperty
  a_uart: assert property (p_uart) else $error("UART boot not taken"); // RQ7

  property p_can;
    @(posedge clk) disable iff (!rst_n)
    (state_q == S_SCAN && init_done && !(map.uart_en && uart_ok_q && !uart_receive_line)
      && map.can_en && can_ok_q && !can_receive_line)
      |=> (boot.valid && boot.chan == BMS_CHAN_CAN);
  endproperty
  a_can: assert property (p_can) else $error("CAN boot not taken"); // RQ8

  sequence s_match;
    state_q == S_WAIT_SIG && sig_done && sig_match;
  endsequence
  property p_srst;
    @(posedge clk) disable iff (!rst_n || !reset_input_pin_n)
    s_match |=> ##1 soft_reset [*8] ##1 (mode == BMS_MODE_USER);
  endproperty
  a_srst: assert property (p_srst) else $error("soft reset sequence wrong"); // RQ10

  property p_halt;
    @(posedge clk) disable iff (!rst_n || !reset_input_pin_n)
    (state_q == S_WAIT_SIG && sig_done && !sig_match && key_word != BMS_KEY_LOADER
      && key_word != BMS_KEY_UART && key_word != BMS_KEY_CAN) |=> halted;
  endproperty
  a_halt: assert property (p_halt) else $error("unknown key did not halt"); // RQ12
endmodule
`default_nettype wire

//--- core/bms_sig_check.sv
// Signature check of two reserved flash words against a reference.
// Assumes the flash words are stable while start is high.
`timescale 1ns/10ps
`default_nettype none
module bms_sig_check #(
  parameter int W = 16
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic start,
  input wire logic [W-1:0] word_a,
  input wire logic [W-1:0] word_b,
  input wire logic [W-1:0] ref_sig,
  output logic done,
  output logic match
);
  import bms_pkg::*;

  // Signature is the sum of the two locations
  logic [W-1:0] sig;
  assign sig = W'(word_a + word_b);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      done <= 1'b0;
      match <= 1'b0;
    end
    else
    begin
      done <= start;
      if (start)
        match <= (sig == ref_sig); // RQ9
    end
  end

  // Sum wraps at W bits on purpose
  property p_sig;
    @(posedge clk) disable iff (!rst_n)
    start |=> (done && match == (W'($past(word_a) + $past(word_b)) == $past(ref_sig)));
  endproperty
  a_sig: assert property (p_sig) else $error("signature compare wrong"); // RQ9
endmodule
`default_nettype wire

//--- sim/bms_boot_mode_selector_tb.sv
// Testbench for the boot mode selector, one task per scenario.
// Assumes the host model owns both receive lines.
`timescale 1ns/10ps
`default_nettype none
module bms_boot_mode_selector_tb;
  import bms_pkg::*;
  logic clk;
  logic arst_n;
  logic reset_input_pin_n;
  logic [1:0] boot_config_pins;
  logic init_done;
  wire logic uart_line;
  wire logic can_line;
  logic [15:0] sig_word_a;
  logic [15:0] sig_word_b;
  logic [15:0] ref_sig;
  logic [15:0] key_word;
  bms_mode_e mode;
  bms_map_s map;
  bms_boot_s boot;
  logic reserved_cfg;
  logic soft_reset;
  logic halted;
  int n_errors;
  int n_checks;
  int cnt;

  bms_boot_mode_selector u_dut (.clk(clk), .arst_n(arst_n),
    .reset_input_pin_n(reset_input_pin_n), .boot_config_pins(boot_config_pins),
    .init_done(init_done), .uart_receive_line(uart_line), .can_receive_line(can_line),
    .sig_word_a(sig_word_a), .sig_word_b(sig_word_b), .ref_sig(ref_sig),
    .key_word(key_word), .mode(mode), .map(map), .boot(boot),
    .reserved_cfg(reserved_cfg), .soft_reset(soft_reset), .halted(halted));
  bms_host_model u_host (.clk(clk), .uart_receive_line(uart_line),
    .can_receive_line(can_line));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic print_verdict();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("FAIL t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic expired();
    n_errors++;
    $display("FAIL t=%0t wait expired", $time);
    print_verdict();
  endtask

  // External reset pulse; pins flipped after the rise must be ignored
  task automatic boot_cfg(input logic [1:0] cfg);
    @(negedge clk);
    init_done = 1'b0;
    reset_input_pin_n = 1'b0;
    boot_config_pins = cfg;
    repeat (3) @(negedge clk);
    reset_input_pin_n = 1'b1;
    boot_config_pins = ~cfg;
    repeat (4) @(negedge clk);
    init_done = 1'b1;
  endtask

  task automatic t_user();
    boot_cfg(2'h3);
    chk(mode, BMS_MODE_USER);
    chk(map.user_map, 1'b1);
    chk(map.fetch_redirect, 1'b0);
    chk(reserved_cfg, 1'b0);
    $display("user test done");
  endtask

  task automatic t_loader(input logic use_can);
    boot_cfg(2'h2);
    chk(mode, BMS_MODE_LOADER);
    chk(map.fetch_redirect, 1'b1);
    chk({map.uart_en, map.can_en}, 2'b11);
    chk(boot.valid, 1'b0);
    if (use_can)
      u_host.send_can(3);
    else
      u_host.send_uart(1);
    cnt = 0;
    while (boot.valid !== 1'b1)
    begin
      if (++cnt > 10)
        expired();
      @(negedge clk);
    end
    chk(boot.chan, use_can ? BMS_CHAN_CAN : BMS_CHAN_UART);
    $display("loader test done");
  endtask

  task automatic t_reserved();
    boot_cfg(2'h0);
    chk(reserved_cfg, 1'b1);
    chk(mode, BMS_MODE_USER);
    $display("reserved test done");
  endtask

  // Sum wraps past 16 bits, so a carry slip shows up
  task automatic t_match();
    sig_word_a = 16'h1234;
    sig_word_b = 16'hf0f0;
    ref_sig = 16'h0324;
    boot_cfg(2'h1);
    chk(mode, BMS_MODE_SELECTIVE);
    chk(map.fetch_redirect, 1'b1);
    cnt = 0;
    while (soft_reset !== 1'b1)
    begin
      if (++cnt > 20)
        expired();
      @(negedge clk);
    end
    cnt = 0;
    while (soft_reset === 1'b1 && cnt < 20)
    begin
      cnt++;
      @(negedge clk);
    end
    chk(cnt, BMS_SRST_CYC);
    chk(mode, BMS_MODE_USER);
    chk(map.fetch_redirect, 1'b0);
    $display("match test done");
  endtask

  task automatic t_keys();
    logic [15:0] keys [4];
    logic [2:0] exp [4];
    keys = '{BMS_KEY_LOADER, BMS_KEY_UART, BMS_KEY_CAN, 16'h00a5};
    exp = '{3'b110, 3'b100, 3'b010, 3'b001};
    ref_sig = 16'h0000;
    for (int k = 0; k < 4; k++)
    begin
      key_word = keys[k];
      boot_cfg(2'h1);
      repeat (10) @(negedge clk);
      chk({map.uart_en, map.can_en, halted}, exp[k]);
      chk(mode, (k == 3) ? BMS_MODE_HALT :
        (k == 0) ? BMS_MODE_LOADER : BMS_MODE_SELECTIVE);
      chk(soft_reset, 1'b0);
      if (k == 1)
      begin
        u_host.send_can(2);
        repeat (6) @(negedge clk);
        chk(boot.valid, 1'b0);
      end
    end
    $display("key test done");
  endtask

  initial
  begin
    n_errors = 0;
    n_checks = 0;
    arst_n = 1'b0;
    reset_input_pin_n = 1'b1;
    boot_config_pins = 2'h3;
    init_done = 1'b0;
    sig_word_a = 16'h0000;
    sig_word_b = 16'h0000;
    ref_sig = 16'h0000;
    key_word = 16'h0000;
    repeat (8) @(negedge clk);
    arst_n = 1'b1;
    repeat (4) @(negedge clk);
    t_user();
    t_loader(1'b0);
    t_loader(1'b1);
    t_reserved();
    t_match();
    t_keys();
    print_verdict();
  end
endmodule
`default_nettype wire

//--- sim/bms_host_model.sv
// Host model that drives the UART and CAN receive lines.
// Assumes pulled-up lines: released lines sit at the idle high level.
`timescale 1ns/10ps
`default_nettype none
module bms_host_model (
  input wire logic clk,
  output logic uart_receive_line,
  output logic can_receive_line
);
  initial
  begin
    uart_receive_line = 1'b1;
    can_receive_line = 1'b1;
  end

  // Start bit, held for bit_cyc clocks so a slow host can be modelled
  task automatic send_uart(input int bit_cyc);
    @(negedge clk);
    uart_receive_line = 1'b0;
    repeat (bit_cyc) @(negedge clk);
    uart_receive_line = 1'b1;
  endtask

  // Dominant bit, then back to recessive
  task automatic send_can(input int bit_cyc);
    @(negedge clk);
    can_receive_line = 1'b0;
    repeat (bit_cyc) @(negedge clk);
    can_receive_line = 1'b1;
  endtask
endmodule
`default_nettype wire
